// *** design/plp_lock_prescaler_regs.sv ***
/*
  axi4-lite register block for lock readback and first prescaler control.
  assumes the lock detector gives a one-cycle measurement strobe with its
  result, and a lock level, both synchronous to clock.
*/
`timescale 1ns/100ps
// Behaviour
// - low eight error bits read at index 0x01e.
// - error bits 9:8 sit in status bits 1:0 at index 0x01f.
// - status bit 3 gives error unit: 0 ppb, 1 ppm.
// - status bit 2 shows lock state, 1 when locked.
// - status bit 4 set when a measurement has completed.
// - ratio field 4:3 picks 2, 2.5, 3, 3.5; resets to 10.
// - prescaler output feeds channel dividers one and two.
// - bit 2 regulator enable, bit 1 prescaler enable, both reset to 1.
// - writing 1 to bit 0 resets prescaler at once, then self-clears.
// - measurements run only while the start bit is 1.
module plp_lock_prescaler_regs (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic [plp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [plp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      meas_valid,
  input  wire logic [9:0]                meas_error,
  input  wire logic                      meas_unit_ppm,
  input  wire logic                      pll_locked,
  output logic                           lock_detector_start,
  output logic [1:0]                     first_prescaler_ratio,
  output logic                           first_prescaler_regulator_enable,
  output logic                           first_prescaler_enable,
  output logic                           first_prescaler_reset,
  output logic                           channel_divider_one_tick,
  output logic                           channel_divider_two_tick,
  output logic                           irq
);
  // bus group
  logic                       awready_ff, nxt_awready;
  logic                       wready_ff, nxt_wready;
  logic                       aw_held_ff, nxt_aw_held;
  logic                       w_held_ff, nxt_w_held;
  logic [plp_pkg::IDX_W-1:0]  wr_idx_ff, nxt_wr_idx;
  logic [31:0]                wdata_ff, nxt_wdata;
  logic                       wstrb0_ff, nxt_wstrb0;
  logic                       bvalid_ff, nxt_bvalid;
  logic [1:0]                 bresp_ff, nxt_bresp;
  logic                       arready_ff, nxt_arready;
  logic                       rvalid_ff, nxt_rvalid;
  logic [31:0]                rdata_ff, nxt_rdata;
  logic [1:0]                 rresp_ff, nxt_rresp;
  logic                       aw_take, w_take, ar_take, do_write;
  logic [plp_pkg::IDX_W-1:0]  rd_idx;

  // core group
  logic [9:0]                 err_ff, nxt_err;
  logic                       unit_ff, nxt_unit;
  logic                       done_ff, nxt_done;
  logic                       locked_ff, nxt_locked;
  logic                       start_ff, nxt_start;
  logic [1:0]                 ratio_ff, nxt_ratio;
  logic                       ldo_ff, nxt_ldo;
  logic                       en_ff, nxt_en;
  logic                       ps_rst_ff, nxt_ps_rst;
  logic [plp_pkg::IRQ_N-1:0]  sts_ff, nxt_sts;
  logic [plp_pkg::IRQ_N-1:0]  irq_en_ff, nxt_irq_en;
  logic                       irq_ff, nxt_irq;
  logic                       tick1_ff, tick2_ff;
  logic                       capture, wr_byte;
  logic [plp_pkg::IRQ_N-1:0]  events, clr_mask;
  logic [7:0]                 status_byte, prescale_byte;

  plp_pscl_if pscl ();

  plp_prescaler u_prescaler (
    .clock (clock),
    .rst   (rst),
    .pscl  (pscl.core)
  );

  assign pscl.ratio            = ratio_ff;
  assign pscl.enable           = en_ff;
  assign pscl.regulator_enable = ldo_ff;
  assign pscl.reset_pulse      = ps_rst_ff;

  assign status_byte = {3'h0, done_ff, unit_ff, locked_ff, err_ff[9:8]};
  // reset bit is write-only, so it always reads back zero
  assign prescale_byte = {3'h0, ratio_ff, ldo_ff, en_ff, 1'b0};

  assign aw_take  = s_axi_awvalid && awready_ff;
  assign w_take   = s_axi_wvalid && wready_ff;
  assign ar_take  = s_axi_arvalid && arready_ff;
  assign do_write = aw_held_ff && w_held_ff;
  assign rd_idx   = plp_pkg::word_idx(s_axi_araddr);
  assign wr_byte  = do_write && wstrb0_ff;

  // bus: address and data taken in either order, answered together
  always_comb begin
    nxt_aw_held = (aw_held_ff && !do_write) || aw_take;
    nxt_w_held  = (w_held_ff && !do_write) || w_take;
    nxt_wr_idx  = aw_take ? plp_pkg::word_idx(s_axi_awaddr) : wr_idx_ff;
    nxt_wdata   = w_take ? s_axi_wdata : wdata_ff;
    nxt_wstrb0  = w_take ? s_axi_wstrb[0] : wstrb0_ff;
    nxt_bvalid  = do_write || (bvalid_ff && !s_axi_bready);
    nxt_bresp   = bresp_ff;
    if (do_write) begin
      case (wr_idx_ff)
        plp_pkg::IDX_ERR_LOW, plp_pkg::IDX_STATUS, plp_pkg::IDX_PRESCALE,
        plp_pkg::IDX_START, plp_pkg::IDX_IRQ_STS, plp_pkg::IDX_IRQ_CLR,
        plp_pkg::IDX_IRQ_EN: nxt_bresp = plp_pkg::RESP_OKAY;
        default:             nxt_bresp = plp_pkg::RESP_SLVERR;
      endcase
    end
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready  = !nxt_w_held && !nxt_bvalid;
    nxt_rvalid  = ar_take || (rvalid_ff && !s_axi_rready);
    nxt_arready = !nxt_rvalid;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    // reads only sample state; no flag is touched by them
    if (ar_take) begin
      nxt_rresp = plp_pkg::RESP_OKAY;
      case (rd_idx)
        plp_pkg::IDX_ERR_LOW:  nxt_rdata = {24'h0, err_ff[7:0]};
        plp_pkg::IDX_STATUS:   nxt_rdata = {24'h0, status_byte};
        plp_pkg::IDX_PRESCALE: nxt_rdata = {24'h0, prescale_byte};
        plp_pkg::IDX_START: begin
          nxt_rdata = 32'h0;
          nxt_rdata[plp_pkg::START_BIT] = start_ff;
        end
        plp_pkg::IDX_IRQ_STS:  nxt_rdata = {29'h0, sts_ff};
        plp_pkg::IDX_IRQ_CLR:  nxt_rdata = 32'h0;
        plp_pkg::IDX_IRQ_EN:   nxt_rdata = {29'h0, irq_en_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = plp_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      wr_idx_ff  <= 10'h000;
      wdata_ff   <= 32'h0;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= 2'h0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      wr_idx_ff  <= nxt_wr_idx;
      wdata_ff   <= nxt_wdata;
      wstrb0_ff  <= nxt_wstrb0;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // core: measurement capture, prescaler control, interrupts
  always_comb begin
    capture    = meas_valid && start_ff;
    nxt_err    = capture ? meas_error : err_ff;
    nxt_unit   = capture ? meas_unit_ppm : unit_ff;
    nxt_locked = pll_locked;
    nxt_start  = start_ff;
    nxt_ratio  = ratio_ff;
    nxt_ldo    = ldo_ff;
    nxt_en     = en_ff;
    nxt_ps_rst = 1'b0;
    nxt_irq_en = irq_en_ff;
    clr_mask   = '0;
    if (wr_byte) begin
      case (wr_idx_ff)
        plp_pkg::IDX_PRESCALE: begin
          // reserved bits 7:5 are dropped on write
          nxt_ratio  = wdata_ff[plp_pkg::PS_RATIO_LSB +: 2];
          nxt_ldo    = wdata_ff[plp_pkg::PS_LDO];
          nxt_en     = wdata_ff[plp_pkg::PS_EN];
          nxt_ps_rst = wdata_ff[plp_pkg::PS_RESET];
        end
        plp_pkg::IDX_START:   nxt_start  = wdata_ff[plp_pkg::START_BIT];
        plp_pkg::IDX_IRQ_CLR: clr_mask   = wdata_ff[plp_pkg::IRQ_N-1:0];
        plp_pkg::IDX_IRQ_EN:  nxt_irq_en = wdata_ff[plp_pkg::IRQ_N-1:0];
        default: ;
      endcase
    end
    // a stopped detector has no completed measurement to report
    nxt_done = nxt_start && (done_ff || capture);
    events = '0;
    events[plp_pkg::IRQ_DONE]      = capture;
    events[plp_pkg::IRQ_LOCK_UP]   = pll_locked && !locked_ff;
    events[plp_pkg::IRQ_LOCK_DOWN] = !pll_locked && locked_ff;
    // set beats clear so an event landing on the clear is kept
    nxt_sts = (sts_ff & ~clr_mask) | events;
    nxt_irq = |(nxt_sts & nxt_irq_en);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      err_ff    <= 10'h000;
      unit_ff   <= 1'b0;
      done_ff   <= 1'b0;
      locked_ff <= 1'b0;
      start_ff  <= 1'b0;
      ratio_ff  <= plp_pkg::PS_RESET_VAL[plp_pkg::PS_RATIO_LSB +: 2];
      ldo_ff    <= plp_pkg::PS_RESET_VAL[plp_pkg::PS_LDO];
      en_ff     <= plp_pkg::PS_RESET_VAL[plp_pkg::PS_EN];
      ps_rst_ff <= 1'b0;
      sts_ff    <= '0;
      irq_en_ff <= '0;
      irq_ff    <= 1'b0;
      tick1_ff  <= 1'b0;
      tick2_ff  <= 1'b0;
    end else begin
      err_ff    <= nxt_err;
      unit_ff   <= nxt_unit;
      done_ff   <= nxt_done;
      locked_ff <= nxt_locked;
      start_ff  <= nxt_start;
      ratio_ff  <= nxt_ratio;
      ldo_ff    <= nxt_ldo;
      en_ff     <= nxt_en;
      ps_rst_ff <= nxt_ps_rst;
      sts_ff    <= nxt_sts;
      irq_en_ff <= nxt_irq_en;
      irq_ff    <= nxt_irq;
      tick1_ff  <= pscl.tick;
      tick2_ff  <= pscl.tick;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  assign lock_detector_start              = start_ff;
  assign first_prescaler_ratio            = ratio_ff;
  assign first_prescaler_regulator_enable = ldo_ff;
  assign first_prescaler_enable           = en_ff;
  assign first_prescaler_reset            = ps_rst_ff;
  assign channel_divider_one_tick         = tick1_ff;
  assign channel_divider_two_tick         = tick2_ff;
  assign irq                              = irq_ff;

  // checks
  sequence reset_write_seq;
    wr_byte && wr_idx_ff == plp_pkg::IDX_PRESCALE && wdata_ff[plp_pkg::PS_RESET];
  endsequence
  sequence one_pulse_seq;
    first_prescaler_reset ##1 !first_prescaler_reset;
  endsequence

  chk_err_low_read: assert property (@(posedge clock) disable iff (rst)
    ar_take && rd_idx == plp_pkg::IDX_ERR_LOW |=> s_axi_rdata == {24'h0, $past(err_ff[7:0])})
    else $error("error low byte read wrong");

  chk_status_read: assert property (@(posedge clock) disable iff (rst)
    ar_take && rd_idx == plp_pkg::IDX_STATUS |=>
      s_axi_rdata[31:5] == 27'h0 && s_axi_rdata[1:0] == $past(err_ff[9:8]))
    else $error("status byte read wrong");

  chk_unit_capture: assert property (@(posedge clock) disable iff (rst)
    capture |=> unit_ff == $past(meas_unit_ppm))
    else $error("error unit not captured");

  chk_lock_follow: assert property (@(posedge clock) disable iff (rst)
    ##1 locked_ff == $past(pll_locked))
    else $error("lock bit does not follow lock input");

  chk_done_set: assert property (@(posedge clock) disable iff (rst)
    capture && !(wr_byte && wr_idx_ff == plp_pkg::IDX_START) |=> done_ff)
    else $error("done flag not set after measurement");

  chk_ctrl_reset: assert property (@(posedge clock)
    rst |=> first_prescaler_ratio == 2'h2 && first_prescaler_enable
            && first_prescaler_regulator_enable)
    else $error("prescaler control reset value wrong");

  chk_ratio_write: assert property (@(posedge clock) disable iff (rst)
    wr_byte && wr_idx_ff == plp_pkg::IDX_PRESCALE |=>
      first_prescaler_ratio == $past(wdata_ff[4:3]) && first_prescaler_enable == $past(wdata_ff[1]))
    else $error("prescaler control write not applied");

  chk_reset_pulse: assert property (@(posedge clock) disable iff (rst)
    reset_write_seq |=> one_pulse_seq)
    else $error("prescaler reset not a single pulse");

  chk_ticks_paired: assert property (@(posedge clock) disable iff (rst)
    channel_divider_one_tick == channel_divider_two_tick)
    else $error("channel divider ticks differ");

  chk_start_gate: assert property (@(posedge clock) disable iff (rst)
    !start_ff && !(wr_byte && wr_idx_ff == plp_pkg::IDX_START) |=> !done_ff && $stable(err_ff))
    else $error("measurement taken while stopped");

  chk_read_quiet: assert property (@(posedge clock) disable iff (rst)
    ar_take && !do_write && !capture && start_ff |=> done_ff == $past(done_ff))
    else $error("read disturbed done flag");

  chk_status_flags: assert property (@(posedge clock) disable iff (rst)
    ar_take && rd_idx == plp_pkg::IDX_STATUS |=>
      s_axi_rdata[plp_pkg::ST_DONE] == $past(done_ff)
      && s_axi_rdata[plp_pkg::ST_UNIT] == $past(unit_ff)
      && s_axi_rdata[plp_pkg::ST_LOCKED] == $past(locked_ff))
    else $error("status flag bits read wrong");

  chk_err_capture: assert property (@(posedge clock) disable iff (rst)
    capture |=> err_ff == $past(meas_error))
    else $error("error magnitude not captured");

  chk_regulator_write: assert property (@(posedge clock) disable iff (rst)
    wr_byte && wr_idx_ff == plp_pkg::IDX_PRESCALE |=>
      first_prescaler_regulator_enable == $past(wdata_ff[plp_pkg::PS_LDO]))
    else $error("regulator enable write not applied");

  chk_reset_reads_zero: assert property (@(posedge clock) disable iff (rst)
    ar_take && rd_idx == plp_pkg::IDX_PRESCALE |=> !s_axi_rdata[plp_pkg::PS_RESET])
    else $error("prescaler reset bit read back set");

  chk_event_sticky: assert property (@(posedge clock) disable iff (rst)
    capture |=> sts_ff[plp_pkg::IRQ_DONE])
    else $error("measurement event not latched");
endmodule

// *** design/plp_pkg.sv ***
/*
  package of the lock readback and first prescaler register block.
  assumes a 32-bit axi4-lite bus with 12-bit byte addresses.
*/
package plp_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;

  // word indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ERR_LOW  = 10'h01e;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 10'h01f;
  localparam logic [IDX_W-1:0] IDX_PRESCALE = 10'h020;
  localparam logic [IDX_W-1:0] IDX_START    = 10'h040;
  localparam logic [IDX_W-1:0] IDX_IRQ_STS  = 10'h041;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 10'h042;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 10'h043;

  // status byte fields
  localparam int unsigned ST_ERR_HI_LSB = 0;
  localparam int unsigned ST_LOCKED     = 2;
  localparam int unsigned ST_UNIT       = 3;
  localparam int unsigned ST_DONE       = 4;

  // prescaler control fields
  localparam int unsigned PS_RESET      = 0;
  localparam int unsigned PS_EN         = 1;
  localparam int unsigned PS_LDO        = 2;
  localparam int unsigned PS_RATIO_LSB  = 3;
  localparam logic [7:0]  PS_RESET_VAL  = 8'h16;

  // start register and interrupt bits
  localparam int unsigned START_BIT     = 4;
  localparam int unsigned IRQ_N         = 3;
  localparam int unsigned IRQ_DONE      = 0;
  localparam int unsigned IRQ_LOCK_UP   = 1;
  localparam int unsigned IRQ_LOCK_DOWN = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ratio code to division ratio in half steps: 2, 2.5, 3, 3.5
  function automatic logic [3:0] ratio_half(input logic [1:0] code);
    ratio_half = 4'h4 + {2'h0, code};
  endfunction

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] addr);
    word_idx = addr[ADDR_W-1:2];
  endfunction
endpackage

// *** design/plp_pscl_if.sv ***
/*
  carrier between the register block and the first prescaler model.
  assumes both ends share the register clock.
*/
`timescale 1ns/100ps
interface plp_pscl_if;
  logic [1:0] ratio;
  logic       enable;
  logic       regulator_enable;
  logic       reset_pulse;
  logic       tick;

  modport ctrl (output ratio, output enable, output regulator_enable,
                output reset_pulse, input tick);
  modport core (input ratio, input enable, input regulator_enable,
                input reset_pulse, output tick);
endinterface

// *** design/plp_prescaler.sv ***
/*
  first prescaler model: emits ticks at the register clock divided by
  2, 2.5, 3 or 3.5 on average.
  assumes control comes from the register block on the same clock.
*/
`timescale 1ns/100ps
module plp_prescaler (
  input wire logic clock,
  input wire logic rst,
  plp_pscl_if.core pscl
);
  logic [3:0] acc_ff;
  logic [3:0] nxt_acc;
  logic       tick_ff;
  logic       nxt_tick;
  logic [3:0] sum;

  // half-step accumulator: fractional ratios dither between whole counts
  always_comb begin
    sum      = acc_ff + 4'h2;
    nxt_acc  = sum;
    nxt_tick = 1'b0;
    if (pscl.reset_pulse || !pscl.enable || !pscl.regulator_enable) begin
      nxt_acc = 4'h0;
    end else if (sum >= plp_pkg::ratio_half(pscl.ratio)) begin
      nxt_acc  = sum - plp_pkg::ratio_half(pscl.ratio);
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign pscl.tick = tick_ff;

  chk_tick_spacing: assert property (@(posedge clock) disable iff (rst)
    tick_ff |=> !tick_ff)
    else $error("prescaler ticked twice in a row");

  chk_off_quiet: assert property (@(posedge clock) disable iff (rst)
    (!pscl.enable || !pscl.regulator_enable) |=> !tick_ff)
    else $error("prescaler ticked while disabled");
endmodule

// *** verification/plp_testbench.sv ***
/*
  self-checking bench for the lock readback and first prescaler register block.
  assumes the design package is compiled first; drives the axi4-lite port itself.
*/
`timescale 1ns/100ps
module testbench;
  logic        clock;
  logic        rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ratio;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, meas_valid, meas_unit_ppm, pll_locked;
  logic [9:0]  meas_error;
  logic        start, reg_en, ps_en, ps_rst, tick_one, tick_two, irq;
  int          n_mismatch, cmp_count, tick_cnt, pulse_cnt;
  int          m_err, m_unit, m_done, m_lock, m_ctrl;
  logic [31:0] rd;
  logic [1:0]  rsp;

  plp_lock_prescaler_regs dut_u (
    .clock(clock), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .meas_valid(meas_valid), .meas_error(meas_error), .meas_unit_ppm(meas_unit_ppm),
    .pll_locked(pll_locked), .lock_detector_start(start), .first_prescaler_ratio(ratio),
    .first_prescaler_regulator_enable(reg_en), .first_prescaler_enable(ps_en),
    .first_prescaler_reset(ps_rst), .channel_divider_one_tick(tick_one),
    .channel_divider_two_tick(tick_two), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // both channels hold their payload until their own ready edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] exp_rsp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200) n_mismatch++;
    chk({30'h0, s_axi_bresp}, {30'h0, exp_rsp});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_rsp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200) n_mismatch++;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, exp_rsp});
  endtask

  task automatic meas(input logic [9:0] e, input logic u);
    meas_valid <= 1'b1;
    meas_error <= e;
    meas_unit_ppm <= u;
    @(posedge clock);
    meas_valid <= 1'b0;
    meas_error <= ~e;
    meas_unit_ppm <= ~u;
    if (start === 1'b1) begin
      m_err = e;
      m_unit = u;
      m_done = 1;
    end
    repeat (3) @(posedge clock);
  endtask

  function automatic logic [31:0] status_exp();
    return 32'(((m_done & 1) << 4) | (m_unit << 3) | (m_lock << 2) | (m_err >> 8));
  endfunction

  // ticks of the two channel dividers must match every cycle
  always @(posedge clock) begin
    if (tick_one === 1'b1) tick_cnt++;
    if (ps_rst === 1'b1) pulse_cnt++;
    if (!rst && tick_one !== tick_two) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, tick_two, tick_one);
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    summarize();
  end

  initial begin
    int unsigned rnd;
    int exp_t, p;
    logic [31:0] d;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    // responses are always taken at once, so ready never toggles between calls
    {s_axi_bready, s_axi_rready} = 2'h3;
    {meas_valid, meas_error, meas_unit_ppm, pll_locked} = '0;
    {n_mismatch, cmp_count, tick_cnt, pulse_cnt, m_err, m_unit, m_done, m_lock} = '0;
    m_ctrl = 32'h16;
    rnd = $urandom(32'h35f9);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({27'h0, ratio, reg_en, ps_en, ps_rst}, 32'h16);
    rdc(12'h080, m_ctrl, plp_pkg::RESP_OKAY);
    rdc(12'h07c, 32'h0, plp_pkg::RESP_OKAY);
    rdc(12'h0f0, 32'h0, plp_pkg::RESP_SLVERR);
    wr(12'h0f4, 32'h1, 4'hf, plp_pkg::RESP_SLVERR);
    pll_locked <= 1'b1;
    m_lock = 1;
    repeat (3) @(posedge clock);
    rdc(12'h07c, status_exp(), plp_pkg::RESP_OKAY);
    rdc(12'h104, 32'h2, plp_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    meas(10'h155, 1'b1);
    rdc(12'h07c, status_exp(), plp_pkg::RESP_OKAY);
    wr(12'h100, 32'h10, 4'h1, plp_pkg::RESP_OKAY);
    rdc(12'h100, 32'h10, plp_pkg::RESP_OKAY);
    chk({31'h0, start}, 32'h1);
    wr(12'h10c, 32'h7, 4'h1, plp_pkg::RESP_OKAY);
    wr(12'h108, 32'h7, 4'h1, plp_pkg::RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rnd = $urandom;
      meas(rnd[9:0], rnd[10]);
      chk({31'h0, irq}, 32'h1);
      rdc(12'h078, 32'(m_err & 8'hff), plp_pkg::RESP_OKAY);
      rdc(12'h07c, status_exp(), plp_pkg::RESP_OKAY);
      rdc(12'h07c, status_exp(), plp_pkg::RESP_OKAY);
      rdc(12'h104, 32'h1, plp_pkg::RESP_OKAY);
      wr(12'h108, 32'h1, 4'h1, plp_pkg::RESP_OKAY);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
    end
    // masked event must not raise the line
    wr(12'h10c, 32'h3, 4'h1, plp_pkg::RESP_OKAY);
    pll_locked <= 1'b0;
    m_lock = 0;
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    wr(12'h10c, 32'h7, 4'h1, plp_pkg::RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(12'h108, 32'h4, 4'h1, plp_pkg::RESP_OKAY);
    rdc(12'h104, 32'h0, plp_pkg::RESP_OKAY);
    // status is read-only; a write is answered but ignored
    wr(12'h07c, 32'h0, 4'h1, plp_pkg::RESP_OKAY);
    rdc(12'h07c, status_exp(), plp_pkg::RESP_OKAY);
    wr(12'h100, 32'h0, 4'h1, plp_pkg::RESP_OKAY);
    meas(10'h3ff, 1'b0);
    m_done = 0;
    rdc(12'h07c, status_exp(), plp_pkg::RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      d = 32'((c << 3) | 6);
      wr(12'h080, d, 4'h1, plp_pkg::RESP_OKAY);
      m_ctrl = d;
      rdc(12'h080, m_ctrl, plp_pkg::RESP_OKAY);
      chk({30'h0, ratio}, 32'(c));
      tick_cnt = 0;
      repeat (140) @(posedge clock);
      exp_t = 280 / (4 + c);
      p = tick_cnt - exp_t;
      chk(32'(p >= -1 && p <= 1), 32'h1);
    end
    // random enable pair, at least one bit off, so the prescaler stops
    rnd = $urandom_range(2, 0);
    d = 32'h10 | (rnd << 1);
    wr(12'h080, d, 4'h1, plp_pkg::RESP_OKAY);
    m_ctrl = d;
    chk({30'h0, reg_en, ps_en}, rnd);
    repeat (4) @(posedge clock);
    tick_cnt = 0;
    repeat (40) @(posedge clock);
    chk(32'(tick_cnt), 32'h0);
    wr(12'h080, 32'h0e, 4'h0, plp_pkg::RESP_OKAY);
    rdc(12'h080, m_ctrl, plp_pkg::RESP_OKAY);
    pulse_cnt = 0;
    wr(12'h080, 32'h17, 4'h1, plp_pkg::RESP_OKAY);
    wr(12'h080, 32'h17, 4'h1, plp_pkg::RESP_OKAY);
    repeat (3) @(posedge clock);
    chk(32'(pulse_cnt), 32'h2);
    // reset bit clears itself, the other fields keep what was written
    m_ctrl = 32'h17 & 32'h1e;
    rdc(12'h080, m_ctrl, plp_pkg::RESP_OKAY);
    summarize();
  end
endmodule
